/* File: inc/jif_pkg.sv */
package jif_pkg;
   // instruction register
   localparam int IR_WIDTH = 10;
   localparam logic [9:0] IR_RESET = 10'h3ff;
   // instruction codes
   localparam logic [9:0] OP_CONFIG_IO = 10'h00d;
   localparam logic [9:0] OP_RECONFIG_PULSE = 10'h001;
   localparam logic [9:0] OP_ENABLE_HIZ = 10'h2cc;
   localparam logic [9:0] OP_ENABLE_CLAMP = 10'h233;
   localparam logic [9:0] OP_DISABLE = 10'h201;
   localparam logic [9:0] OP_PROGRAM = 10'h2f4;
   localparam logic [9:0] OP_NOOP = 10'h210;
   localparam logic [9:0] OP_ADDRESS_SHIFT = 10'h203;
   localparam logic [9:0] OP_ERASE = 10'h2f2;
   localparam logic [9:0] OP_READ = 10'h205;
   localparam logic [9:0] OP_BG_ENABLE = 10'h199;
   localparam logic [9:0] OP_BG_DISABLE = 10'h166;
   localparam logic [9:0] OP_BYPASS = 10'h3ff;
   // widths
   localparam int ADDR_WIDTH = 23;
   localparam int DATA_WIDTH = 32;
   // timing: exit wait in run-test/idle, on the link clock (30 ns)
   localparam int DISABLE_WAIT_US = 200;
   localparam int TCK_PERIOD_NS = 30;
   localparam int DISABLE_WAIT_CYC = (DISABLE_WAIT_US * 1000 + TCK_PERIOD_NS - 1) / TCK_PERIOD_NS;
   localparam int WAIT_CNT_W = 13;
   // reconfiguration pulse length in system clocks
   localparam int RECONFIG_PULSE_CYC = 4;
   // tap states, gray along the usual path
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
      TAP_SHIFT_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EX2_DR = 4'h4,
      TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SHIFT_IR = 4'he,
      TAP_EX1_IR = 4'ha, TAP_PAUSE_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
   } jif_tap_type;
endpackage : jif_pkg

/* File: verilog/jif_pulse_sync.sv */
`timescale 1ns/1ps
// toggle-based event crossing into the destination clock
module jif_pulse_sync (
   input wire logic srcClk,
   input wire logic srcRst,
   input wire logic srcPulse,
   input wire logic dstClk,
   input wire logic dstRst,
   output logic dstPulse
);
   logic toggle_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;

   // =========================================
   // source toggle
   always_ff @(posedge srcClk) begin
      if (srcRst) begin
         toggle_reg <= 1'b0;
      end else if (srcPulse) begin
         toggle_reg <= ~toggle_reg;
      end
   end

   // =========================================
   // destination synchroniser and edge
   always_ff @(posedge dstClk) begin
      if (dstRst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         dstPulse <= 1'b0;
      end else begin
         sync1_reg <= toggle_reg;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         dstPulse <= sync2_reg ^ sync3_reg;
      end
   end
endmodule : jif_pulse_sync

/* File: verilog/jif_isp_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - io setup instruction accepted only once config status is high.
// - reconfig-pulse instruction requests reconfiguration, pin untouched.
// - hi-z enable enters programming mode, tri-states pins, core keeps running.
// - programming mode stays until disable instruction loaded and updated.
// - clamp enable enters programming mode, pins from boundary scan, core frozen.
// - disable leaves programming mode after 200 us in run-test/idle.
// - program data-register update arms; flash write pulse issued in run-test/idle.
// - no-op idles inside programming mode, selects default register.
// - address-shift selects flash address register for shifting.
// - erase arms; host loads address first; erase pulse in idle.
// - background enable enters real-time mode while user logic runs.
// - background disable leaves real-time mode, even after reconfiguration.
// - address-shift, program, erase and read ignored outside normal or real-time mode.
// - entering programming mode only via hi-z or clamp enable.
// - program pulse per data-register update, read pulse per read instruction load.
// - serial in on tdi, read data out on tdo.
// - normal mode leaves user mode tri-stated (hi-z enable) or clamped (clamp enable), resets at exit.
// - real-time mode keeps design running, no reset at completion.
module jif_isp_ctrl
   import jif_pkg::*;
#(
   parameter int AW = ADDR_WIDTH,
   parameter int DW = DATA_WIDTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tckRst,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdoEn,
   input wire logic configStatusPin,
   input wire logic [DW-1:0] flashRdData,
   output logic [AW-1:0] flashAddr,
   output logic [DW-1:0] flashWrData,
   output logic flashProgPulse,
   output logic flashErasePulse,
   output logic flashReadPulse,
   output logic reconfigReq,
   output logic ioTristate,
   output logic ioClamp,
   output logic coreFreeze,
   output logic ioSetupSelect,
   output logic ispMode,
   output logic bgMode,
   output logic userReset
);
   jif_tap_type tapState_reg;
   logic [IR_WIDTH-1:0] irShift_reg;
   logic [IR_WIDTH-1:0] ir_reg;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] data_reg;
   logic bypass_reg;
   logic isp_reg;
   logic bg_reg;
   logic clamp_reg;
   logic armProg_reg;
   logic armErase_reg;
   logic armRead_reg;
   logic idleDone_reg;
   logic [WAIT_CNT_W-1:0] wait_reg;
   logic statusSync1_reg;
   logic statusSync2_reg;
   logic reconfigSys;
   logic exitSys;
   logic [2:0] pulseCnt_reg;
   logic enterIsp;
   logic active;

   // =========================================
   // decode helpers
   function automatic jif_tap_type tapNext(input jif_tap_type s, input logic m);
      unique case (s)
         TAP_RESET: tapNext = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tapNext = m ? TAP_EX1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tapNext = m ? TAP_EX1_DR : TAP_SHIFT_DR;
         TAP_EX1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tapNext = m ? TAP_EX2_DR : TAP_PAUSE_DR;
         TAP_EX2_DR: tapNext = m ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tapNext = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: tapNext = m ? TAP_EX1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tapNext = m ? TAP_EX1_IR : TAP_SHIFT_IR;
         TAP_EX1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tapNext = m ? TAP_EX2_IR : TAP_PAUSE_IR;
         TAP_EX2_IR: tapNext = m ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction : tapNext

   // =========================================
   // tap state, link domain
   always_ff @(posedge tck) begin
      if (tckRst) begin
         tapState_reg <= TAP_RESET;
      end else begin
         tapState_reg <= tapNext(tapState_reg, tms);
      end
   end

   // =========================================
   // config status into link domain
   always_ff @(posedge tck) begin
      if (tckRst) begin
         statusSync1_reg <= 1'b0;
         statusSync2_reg <= 1'b0;
      end else begin
         statusSync1_reg <= configStatusPin;
         statusSync2_reg <= statusSync1_reg;
      end
   end

   // =========================================
   // instruction register
   always_ff @(posedge tck) begin
      if (tckRst || tapState_reg == TAP_RESET) begin
         irShift_reg <= IR_RESET;
         ir_reg <= IR_RESET;
      end else begin
         if (tapState_reg == TAP_CAP_IR) begin
            irShift_reg <= {{(IR_WIDTH-2){1'b0}}, 2'b01};
         end else if (tapState_reg == TAP_SHIFT_IR) begin
            irShift_reg <= {tdi, irShift_reg[IR_WIDTH-1:1]};
         end
         if (tapState_reg == TAP_UPD_IR) begin
            ir_reg <= irShift_reg;
         end
      end
   end

   assign active = isp_reg || bg_reg;
   assign enterIsp = tapState_reg == TAP_UPD_IR
      && (irShift_reg == OP_ENABLE_HIZ || irShift_reg == OP_ENABLE_CLAMP);

   // =========================================
   // mode flags
   always_ff @(posedge tck) begin
      if (tckRst) begin
         isp_reg <= 1'b0;
         bg_reg <= 1'b0;
         clamp_reg <= 1'b0;
      end else begin
         if (enterIsp) begin
            isp_reg <= 1'b1;
            // hi-z keeps core running; clamp freezes it
            clamp_reg <= irShift_reg == OP_ENABLE_CLAMP;
         end
         // left only after disable wait completes
         if (idleDone_reg) begin
            isp_reg <= 1'b0;
            clamp_reg <= 1'b0;
         end
         if (tapState_reg == TAP_UPD_IR && irShift_reg == OP_BG_ENABLE) begin
            bg_reg <= 1'b1;
         end
         if (tapState_reg == TAP_UPD_IR && irShift_reg == OP_BG_DISABLE) begin
            bg_reg <= 1'b0;
         end
      end
   end

   // =========================================
   // disable wait counter
   always_ff @(posedge tck) begin
      if (tckRst) begin
         wait_reg <= '0;
         idleDone_reg <= 1'b0;
      end else begin
         idleDone_reg <= 1'b0;
         if (ir_reg != OP_DISABLE || !isp_reg || tapState_reg != TAP_IDLE) begin
            wait_reg <= '0;
         end else if (wait_reg == WAIT_CNT_W'(DISABLE_WAIT_CYC - 1)) begin
            idleDone_reg <= 1'b1;
            wait_reg <= '0;
         end else begin
            wait_reg <= wait_reg + 1'b1;
         end
      end
   end

   // =========================================
   // data registers
   always_ff @(posedge tck) begin
      if (tckRst) begin
         addr_reg <= '0;
         data_reg <= '0;
         bypass_reg <= 1'b0;
      end else if (tapState_reg == TAP_SHIFT_DR) begin
         bypass_reg <= tdi;
         // instruction ignored outside a programming mode
         if (active && ir_reg == OP_ADDRESS_SHIFT) begin
            addr_reg <= {tdi, addr_reg[AW-1:1]};
         end else if (active && (ir_reg == OP_PROGRAM || ir_reg == OP_READ)) begin
            data_reg <= {tdi, data_reg[DW-1:1]};
         end
      end else if (tapState_reg == TAP_CAP_DR) begin
         bypass_reg <= 1'b0;
         // read captures flash word for shifting out
         if (active && ir_reg == OP_READ) begin
            data_reg <= flashRdData;
         end
      end else if (tapState_reg == TAP_UPD_DR && active && ir_reg == OP_READ) begin
         // burst mode steps the address after each word
         addr_reg <= addr_reg + 1'b1;
      end
   end

   // =========================================
   // arming and flash pulses
   always_ff @(posedge tck) begin
      if (tckRst) begin
         armProg_reg <= 1'b0;
         armErase_reg <= 1'b0;
         armRead_reg <= 1'b0;
         flashProgPulse <= 1'b0;
         flashErasePulse <= 1'b0;
         flashReadPulse <= 1'b0;
      end else begin
         flashProgPulse <= 1'b0;
         flashErasePulse <= 1'b0;
         flashReadPulse <= 1'b0;
         if (tapState_reg == TAP_UPD_IR || tapState_reg == TAP_UPD_DR) begin
            armProg_reg <= active && tapState_reg == TAP_UPD_DR && ir_reg == OP_PROGRAM;
            armErase_reg <= active && tapState_reg == TAP_UPD_IR && irShift_reg == OP_ERASE;
            armRead_reg <= active && tapState_reg == TAP_UPD_IR && irShift_reg == OP_READ;
         end else if (tapState_reg == TAP_IDLE) begin
            // one pulse per arming update, in run-test/idle
            flashProgPulse <= armProg_reg;
            flashErasePulse <= armErase_reg;
            flashReadPulse <= armRead_reg;
            armProg_reg <= 1'b0;
            armErase_reg <= 1'b0;
            armRead_reg <= 1'b0;
         end
      end
   end

   // =========================================
   // pin and mode outputs
   always_ff @(posedge tck) begin
      if (tckRst) begin
         tdo <= 1'b0;
         tdoEn <= 1'b0;
         ioTristate <= 1'b0;
         ioClamp <= 1'b0;
         coreFreeze <= 1'b0;
         ioSetupSelect <= 1'b0;
         ispMode <= 1'b0;
         bgMode <= 1'b0;
         flashAddr <= '0;
         flashWrData <= '0;
      end else begin
         // read data leaves on tdo while shifting
         tdoEn <= tapState_reg == TAP_SHIFT_DR || tapState_reg == TAP_SHIFT_IR;
         if (tapState_reg == TAP_SHIFT_IR) begin
            tdo <= irShift_reg[0];
         end else if (active && ir_reg == OP_ADDRESS_SHIFT) begin
            tdo <= addr_reg[0];
         end else if (active && (ir_reg == OP_READ || ir_reg == OP_PROGRAM)) begin
            tdo <= data_reg[0];
         end else begin
            // no-op and others use the one-bit default
            tdo <= bypass_reg;
         end
         ioTristate <= isp_reg && !clamp_reg;
         ioClamp <= isp_reg && clamp_reg;
         coreFreeze <= isp_reg && clamp_reg;
         // io setup only once status high
         ioSetupSelect <= ir_reg == OP_CONFIG_IO && statusSync2_reg;
         ispMode <= isp_reg;
         // background mode leaves user pins alone
         bgMode <= bg_reg;
         flashAddr <= addr_reg;
         flashWrData <= data_reg;
      end
   end

   // reconfig requested at update, pin untouched
   jif_pulse_sync u_reconfig_sync (
      .srcClk(tck),
      .srcRst(tckRst),
      .srcPulse(tapState_reg == TAP_UPD_IR && irShift_reg == OP_RECONFIG_PULSE),
      .dstClk(clk),
      .dstRst(srst),
      .dstPulse(reconfigSys)
   );

   jif_pulse_sync u_exit_sync (
      .srcClk(tck),
      .srcRst(tckRst),
      .srcPulse(idleDone_reg),
      .dstClk(clk),
      .dstRst(srst),
      .dstPulse(exitSys)
   );

   // =========================================
   // system-side reconfiguration and reset pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         pulseCnt_reg <= '0;
         reconfigReq <= 1'b0;
         userReset <= 1'b0;
      end else begin
         if (reconfigSys || exitSys) begin
            pulseCnt_reg <= 3'(RECONFIG_PULSE_CYC);
         end else if (pulseCnt_reg != '0) begin
            pulseCnt_reg <= pulseCnt_reg - 1'b1;
         end
         reconfigReq <= reconfigSys || (reconfigReq && pulseCnt_reg > 3'h1);
         userReset <= exitSys || (userReset && pulseCnt_reg > 3'h1);
      end
   end
endmodule : jif_isp_ctrl

/* File: sim/jif_isp_ctrl_sva.sv */
`timescale 1ns/1ps
// ==========================================
// port checker for the isp controller
module jif_isp_ctrl_sva
   import jif_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tckRst,
   input wire logic tms,
   input wire logic configStatusPin,
   input wire logic flashProgPulse,
   input wire logic flashErasePulse,
   input wire logic flashReadPulse,
   input wire logic reconfigReq,
   input wire logic ioTristate,
   input wire logic ioClamp,
   input wire logic coreFreeze,
   input wire logic ioSetupSelect,
   input wire logic ispMode,
   input wire logic bgMode,
   input wire logic userReset
);
   localparam int EXIT_MIN = DISABLE_WAIT_CYC - 8;
   logic [12:0] lowRun_reg;
   // run of consecutive low tms samples
   always_ff @(posedge tck) begin
      if (tckRst || tms) begin
         lowRun_reg <= 13'h0;
      end else if (lowRun_reg != 13'h1fff) begin
         lowRun_reg <= lowRun_reg + 13'h1;
      end
   end
   // ==========================================
   // tck domain
   prog_pulse_one_a: assert property (@(posedge tck) disable iff (tckRst)
      flashProgPulse |=> !flashProgPulse) else $error("program pulse too long");
   pulse_needs_mode_a: assert property (@(posedge tck) disable iff (tckRst)
      (flashProgPulse || flashErasePulse || flashReadPulse) |-> (ispMode || bgMode))
      else $error("flash pulse outside programming mode");
   pulse_excl_a: assert property (@(posedge tck) disable iff (tckRst)
      $onehot0({flashProgPulse, flashErasePulse, flashReadPulse})) else $error("pulses overlap");
   clamp_freeze_a: assert property (@(posedge tck) disable iff (tckRst)
      ioClamp |-> coreFreeze && ispMode && !ioTristate) else $error("clamp without freeze");
   hiz_running_a: assert property (@(posedge tck) disable iff (tckRst)
      ioTristate |-> ispMode && !coreFreeze) else $error("tristate mode wrong");
   exit_wait_a: assert property (@(posedge tck) disable iff (tckRst)
      ($fell(ispMode) || $fell(ioClamp)) |-> lowRun_reg >= EXIT_MIN)
      else $error("mode left before idle wait");
   bg_user_a: assert property (@(posedge tck) disable iff (tckRst)
      (bgMode && !ispMode) |-> !ioTristate && !coreFreeze) else $error("user mode stopped");
   io_setup_a: assert property (@(posedge tck) disable iff (tckRst)
      $rose(ioSetupSelect) |-> $past(configStatusPin, 2)) else $error("io setup while status low");
   // ==========================================
   // clk domain
   reconfig_len_a: assert property (@(posedge clk) disable iff (srst)
      $rose(reconfigReq) |-> reconfigReq[*3] ##[1:3] !reconfigReq) else $error("reconfig length");
   urst_len_a: assert property (@(posedge clk) disable iff (srst)
      $rose(userReset) |-> userReset[*3] ##[1:3] !userReset) else $error("user reset length");
endmodule : jif_isp_ctrl_sva

/* File: sim/jif_jtag_host.sv */
`timescale 1ns/1ps
// ==========================================
// jtag programming host on the tap pins
module jif_jtag_host (
   input wire logic tck,
   input wire logic tdo,
   output logic tms,
   output logic tdi
);
   // pins rest at pull-up level
   initial begin
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one tap step, tdo taken at falling edge
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      @(negedge tck);
      o = tdo;
      @(posedge tck);
      #2;
   endtask : step
   task automatic idle(input int n);
      logic o;
      for (int i = 0; i < n; i++) begin
         step(1'b0, 1'b1, o);
      end
   endtask : idle
   // serial scan from the external host, lsb first
   task automatic scan(input bit ir, input int n, input logic [31:0] v, output logic [31:0] got);
      logic o;
      got = 32'h0;
      step(1'b1, 1'b1, o);
      if (ir) begin
         step(1'b1, 1'b1, o);
      end
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, v[i], o);
         // tdo is a flop that trails the shift register by one tck
         if (i > 0) got[i - 1] = o;
      end
      step(1'b1, 1'b1, o);
      got[n - 1] = o;
      step(1'b0, 1'b1, o);
   endtask : scan
endmodule : jif_jtag_host

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the isp controller
module tb_top;
   import jif_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic tck = 1'b0;
   logic tckRst = 1'b1;
   logic configStatusPin = 1'b0;
   logic [31:0] flashRdData = 32'h0;
   logic tms, tdi, tdo, tdoEn, flashProgPulse, flashErasePulse, flashReadPulse, reconfigReq;
   logic ioTristate, ioClamp, coreFreeze, ioSetupSelect, ispMode, bgMode, userReset;
   logic [22:0] flashAddr;
   logic [31:0] flashWrData, expAddr, v, g;
   logic [9:0] irCur;
   bit expIsp, expBg, expHiz, expClamp;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int progN = 0, eraseN = 0, readN = 0, rcfgN = 0, urstN = 0, enN = 0;
   int expProg = 0, expErase = 0, expRead = 0, expUrst = 0, expEn = 0;
   bit rcfgQ = 1'b0, urstQ = 1'b0;
   // clocks, tck offset in phase
   always #5 clk = ~clk;
   always begin
      if ($time == 0) #2.3;
      #15 tck = ~tck;
   end
   jif_isp_ctrl i_jif_isp_ctrl (.clk(clk), .srst(srst), .tck(tck), .tckRst(tckRst), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .configStatusPin(configStatusPin),
      .flashRdData(flashRdData), .flashAddr(flashAddr), .flashWrData(flashWrData),
      .flashProgPulse(flashProgPulse), .flashErasePulse(flashErasePulse),
      .flashReadPulse(flashReadPulse), .reconfigReq(reconfigReq), .ioTristate(ioTristate),
      .ioClamp(ioClamp), .coreFreeze(coreFreeze), .ioSetupSelect(ioSetupSelect),
      .ispMode(ispMode), .bgMode(bgMode), .userReset(userReset));
   jif_jtag_host i_jif_jtag_host (.tck(tck), .tdo(tdo), .tms(tms), .tdi(tdi));
   // pulse counters and timeout
   always @(posedge tck) begin
      if (flashProgPulse === 1'b1) progN++;
      if (flashErasePulse === 1'b1) eraseN++;
      if (flashReadPulse === 1'b1) readN++;
      if (tdoEn === 1'b1) enN++;
   end
   always @(posedge clk) begin
      if (reconfigReq === 1'b1 && !rcfgQ) rcfgN++;
      if (userReset === 1'b1 && !urstQ) urstN++;
      rcfgQ = reconfigReq === 1'b1;
      urstQ = userReset === 1'b1;
      cyc++;
      if (cyc == 60000) begin
         fails++;
         results();
      end
   end
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chkWord
   task automatic chkCount(input int got, input int exp, input string m);
      compares++;
      if (got != exp) begin
         fails++;
         $display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask : chkCount
   task automatic chkModes();
      chkWord({27'h0, ispMode, bgMode, ioTristate, ioClamp, coreFreeze},
         {27'h0, expIsp, expBg, expHiz, expClamp, expClamp}, "modes");
   endtask : chkModes
   // instruction load and model update, known codes only
   task automatic ir(input logic [9:0] c);
      i_jif_jtag_host.scan(1'b1, IR_WIDTH, {22'h0, c}, g);
      expEn += IR_WIDTH;
      irCur = c;
      case (c)
         OP_ENABLE_HIZ: {expIsp, expHiz} = 2'b11;
         OP_ENABLE_CLAMP: {expIsp, expClamp} = 2'b11;
         OP_BG_ENABLE: expBg = 1'b1;
         OP_BG_DISABLE: expBg = 1'b0;
         OP_ERASE: expErase += int'(expIsp || expBg);
         OP_READ: expRead += int'(expIsp || expBg);
         default: ;
      endcase
      i_jif_jtag_host.idle(4);
   endtask : ir
   task automatic dr(input int n, input logic [31:0] d);
      i_jif_jtag_host.scan(1'b0, n, d, g);
      expEn += n;
      if (expIsp || expBg) begin
         if (irCur == OP_ADDRESS_SHIFT) expAddr = d & 32'h7fffff;
         if (irCur == OP_PROGRAM) expProg++;
         if (irCur == OP_READ) expAddr = (expAddr + 32'h1) & 32'h7fffff;
      end
      i_jif_jtag_host.idle(4);
   endtask : dr
   task automatic leave();
      ir(OP_DISABLE);
      i_jif_jtag_host.idle(100);
      chkModes(); // still in mode
      i_jif_jtag_host.idle(DISABLE_WAIT_CYC);
      {expIsp, expHiz, expClamp} = 3'b0;
      expUrst++;
      chkModes(); // mode left
      chkCount(urstN, expUrst, "user reset"); // reset once
   endtask : leave
   task automatic results();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   // main sequence
   initial begin
      void'($urandom(18));
      expAddr = 32'h0;
      irCur = OP_BYPASS;
      repeat (2) @(posedge clk);
      #2 srst = 1'b0;
      repeat (2) @(posedge tck);
      #2 tckRst = 1'b0;
      i_jif_jtag_host.idle(2);
      ir(OP_ADDRESS_SHIFT);
      dr(ADDR_WIDTH, $urandom());
      ir(OP_ERASE);
      chkWord({9'h0, flashAddr}, expAddr, "refused addr"); // ignored
      chkCount(eraseN, expErase, "refused erase"); // ignored
      $display("test refused done");
      ir(OP_ENABLE_HIZ);
      chkModes(); // hiz entry
      ir(OP_NOOP);
      chkModes(); // mode kept
      ir(OP_ADDRESS_SHIFT);
      v = $urandom();
      dr(ADDR_WIDTH, v);
      chkWord({9'h0, flashAddr}, expAddr, "addr"); // address load
      ir(OP_ERASE);
      chkCount(eraseN, expErase, "erase"); // erase pulse
      ir(OP_PROGRAM);
      v = $urandom();
      dr(DATA_WIDTH, v);
      chkWord(flashWrData, v, "write data"); // data load
      chkCount(progN, expProg, "program"); // program pulse
      flashRdData = $urandom();
      ir(OP_READ);
      chkCount(readN, expRead, "read"); // read pulse
      dr(DATA_WIDTH, $urandom());
      chkWord(g, flashRdData, "read data"); // serial out
      chkWord({9'h0, flashAddr}, expAddr, "burst addr"); // auto increment
      leave();
      $display("test hiz done");
      ir(OP_ENABLE_CLAMP);
      chkModes(); // clamp entry
      ir(OP_NOOP);
      chkModes(); // mode kept
      leave();
      $display("test clamp done");
      ir(OP_BG_ENABLE);
      chkModes(); // user mode runs
      ir(OP_ADDRESS_SHIFT);
      v = $urandom();
      dr(ADDR_WIDTH, v);
      chkWord({9'h0, flashAddr}, expAddr, "bg addr"); // accepted
      ir(OP_RECONFIG_PULSE);
      chkCount(rcfgN, 1, "reconfig"); // request raised
      chkModes(); // mode kept
      ir(OP_BG_DISABLE);
      chkModes(); // mode left
      chkCount(urstN, expUrst, "bg reset"); // no reset
      $display("test background done");
      ir(OP_CONFIG_IO);
      chkWord({31'h0, ioSetupSelect}, 32'h0, "io setup low"); // status low
      configStatusPin = 1'b1;
      i_jif_jtag_host.idle(5);
      chkWord({31'h0, ioSetupSelect}, 32'h1, "io setup high"); // status high
      $display("test io setup done");
      chkCount(enN, expEn, "tdo enable"); // shift window
      results();
   end
endmodule : tb_top
bind jif_isp_ctrl jif_isp_ctrl_sva i_jif_isp_ctrl_sva (.clk, .srst, .tck, .tckRst, .tms,
   .configStatusPin, .flashProgPulse, .flashErasePulse, .flashReadPulse, .reconfigReq,
   .ioTristate, .ioClamp, .coreFreeze, .ioSetupSelect, .ispMode, .bgMode, .userReset);
